//--- rtl/pmbus_ext_regs.svh
// command codes, field positions and timing constants of the bank
`ifndef PMBUS_EXT_REGS_SVH
`define PMBUS_EXT_REGS_SVH
`define CMD_FLAGS 8'hdd
`define CMD_LOG 8'he0
`define CMD_FPIN 8'he3
`define CMD_SYNC 8'he4
`define LEN_FLAGS 4'h7
`define LEN_LOG 4'h8
`define LEN_FPIN 4'h2
`define LEN_SYNC 4'h6
`define FLAGS_MASK 56'hfe_3ef0_170c_c03f
`define FPIN_MASK 16'h0007
`define SYNC_MASK 48'hffff_ffff_dfe0
`define ALL_ONES 56'hff_ffff_ffff_ffff
`define NO_BITS 56'h00_0000_0000_0000
`define B_RO_WRITE 55
`define B_BAD_GROUP 54
`define B_GROUP_READ 53
`define B_COMM_MISC 52
`define B_ABORTED 51
`define B_ARB_LOSS 50
`define B_BLK_NACK 49
`define B_BYTES_FEW 45
`define B_BYTES_MANY 44
`define B_BLK_SHORT 43
`define B_BLK_LONG 42
`define B_LOCKED 41
`define B_POS_OPEN_B 39
`define B_POS_OPEN_A 38
`define B_NEG_OPEN_B 37
`define B_NEG_OPEN_A 36
`define B_ALIGN_FLT 28
`define B_NO_UPDATE 26
`define B_BAD_BOOT 25
`define B_BAD_ADDR 24
`define B_BAD_PHASE 19
`define B_BAD_FILE 18
`define B_AUX_LOW_B 15
`define B_AUX_LOW_A 14
`define B_PRE_OV_B 5
`define B_PRE_OV_A 4
`define B_TRK_OV_B 3
`define B_TRK_OV_A 2
`define B_FIX_OV_B 1
`define B_FIX_OV_A 0
`define FP_OT 2
`define FP_OC 1
`define FP_CHB 0
`define PAGE_A 8'h00
`define PAGE_B 8'h01
`define IN_DIV_MAX 6'h0f
`define RATIO_BAD 3'h4
`define POW2_MAX 4'ha
`define ANGLE_MAX 4'hc
`define LOG_DEPTH 32
`define LOG_PAD 8'h00
`define FRAME_BITS 32
`define BITCNT_LAST 5'h1f
`define BITCNT_ONE 5'h01
`define TS_BITS 24
`define MCLK_PERIOD_NS 25
`define TS_LSB_NS 1000
`define TS_TICK_CYC (`TS_LSB_NS / `MCLK_PERIOD_NS)
`endif

//--- rtl/pmbus_ext_pkg.sv
// types shared by the extended flag and sync configuration bank
package pmbus_ext_pkg;
  typedef struct packed {
    logic       out_en;
    logic [5:0] in_div;
    logic       freq_loop_gain_b;
    logic [1:0] pll_loop_gain_b;
    logic [2:0] freq_ratio_a;
    logic [2:0] freq_ratio_b;
    logic [3:0] angle_offset_b;
    logic [3:0] pwm_pow2_divider_b;
    logic [3:0] angle_offset_a;
    logic [3:0] pwm_pow2_divider_a;
    logic [1:0] pll_loop_gain_a;
    logic       rsvd_13;
    logic       freq_loop_en_b;
    logic       pll_loop_en_b;
    logic       freq_loop_gain_a;
    logic       freq_loop_en_a;
    logic       pll_loop_en_a;
    logic       sync_out_from_b;
    logic       clock_source_b;
    logic       clock_source_a;
    logic [4:0] rsvd_low;
  } sync_cfg_t;
  typedef enum logic [0:0] {
    RX_HUNT = 1'b0,
    RX_BITS = 1'b1
  } rx_state_t;
endpackage

//--- rtl/sticky_bits.sv
// sticky flag bank: set wins over clear, unsupported bits stay zero
`timescale 1ns/1ps
`default_nettype none
module sticky_bits #(
  parameter int          W    = 8,
  parameter logic [W-1:0] MASK = '1
) (
  input  wire logic         mclk,
  input  wire logic         nrst,
  input  wire logic [W-1:0] set_vec,
  input  wire logic [W-1:0] clr_vec,
  output logic      [W-1:0] q
);
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      q <= '0;
    end else begin
      q <= ((q & ~clr_vec) | set_vec) & MASK;
    end
  end
endmodule // sticky_bits
`default_nettype wire

//--- rtl/frame_logger.sv
// serial frame receiver with timestamped circular log
`timescale 1ns/1ps
`default_nettype none
`include "pmbus_ext_regs.svh"
module frame_logger (
  input  wire logic        mclk,
  input  wire logic        nrst,
  input  wire logic        link_clk,
  input  wire logic        link_data,
  input  wire logic [4:0]  entry_index,
  output logic      [63:0] entry_data,
  output logic             frame_done
);
  logic [1:0]  clk_sync;
  logic [1:0]  dat_sync;
  logic        clk_prev;
  logic        rise;
  logic [`TS_BITS-1:0]    stamp;
  logic [5:0]  tick_cnt;
  logic [`FRAME_BITS-1:0] shift;
  logic [4:0]  bit_cnt;
  logic [4:0]  wr_ptr;
  logic [55:0] mem [`LOG_DEPTH];
  pmbus_ext_pkg::rx_state_t state;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      clk_sync <= 2'h0;
      dat_sync <= 2'h0;
      clk_prev <= 1'b0;
    end else begin
      clk_sync <= {clk_sync[0], link_clk};
      dat_sync <= {dat_sync[0], link_data};
      clk_prev <= clk_sync[1];
    end
  end
  assign rise = clk_sync[1] && !clk_prev;

  // microsecond timestamp, wraps at full width
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      tick_cnt <= 6'h00;
      stamp    <= '0;
    end else if (tick_cnt == 6'(`TS_TICK_CYC - 1)) begin
      tick_cnt <= 6'h00;
      stamp    <= stamp + 24'h00_0001; // R15
    end else begin
      tick_cnt <= tick_cnt + 6'h01;
    end
  end

  // a frame opens with a low bit and is 32 bits long
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state      <= pmbus_ext_pkg::RX_HUNT;
      shift      <= '0;
      bit_cnt    <= 5'h00;
      frame_done <= 1'b0;
    end else begin
      frame_done <= 1'b0;
      if (rise) begin
        shift <= {shift[`FRAME_BITS-2:0], dat_sync[1]};
        case (state)
          pmbus_ext_pkg::RX_HUNT: begin
            if (!dat_sync[1]) begin
              state   <= pmbus_ext_pkg::RX_BITS;
              bit_cnt <= `BITCNT_ONE;
            end
          end
          pmbus_ext_pkg::RX_BITS: begin
            bit_cnt <= bit_cnt + 5'h01;
            if (bit_cnt == `BITCNT_LAST) begin
              state      <= pmbus_ext_pkg::RX_HUNT;
              frame_done <= 1'b1;
            end
          end
          default: state <= pmbus_ext_pkg::RX_HUNT;
        endcase
      end
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      wr_ptr <= 5'h00;
      for (int i = 0; i < `LOG_DEPTH; i++) begin
        mem[i] <= '0;
      end
    end else if (frame_done) begin
      mem[wr_ptr] <= {shift, stamp}; // R15
      wr_ptr      <= wr_ptr + 5'h01;
    end
  end

  assign entry_data = {mem[entry_index][55:`TS_BITS], `LOG_PAD,
                       mem[entry_index][`TS_BITS-1:0]};
endmodule // frame_logger
`default_nettype wire

//--- rtl/pmbus_ext_flags_sync_cfg.sv
// extended fault flags, frame log, fault pin select and sync settings
// How it works
// [R01] write to read-only command sets bit 55
// [R02] bad group sets 54, group read 53
// [R03] other communication errors set bit 52
// [R04] master abort sets 51, arbitration loss 50
// [R05] refused block-size byte sets bit 49
// [R06] too few bytes 45, too many 44
// [R07] block size short 43, long 42
// [R08] write while protected sets bit 41
// [R09] sense line opens in bits 39..36
// [R10] sync fault 28, refused update 26
// [R11] address 24, phase map 19, file 18
// [R12] auxiliary output low in bits 15, 14
// [R13] prebias overvoltage in bits 5, 4
// [R14] tracking overvoltage 3,2; fixed 1,0
// [R15] log holds 32 frames with wrapping stamp
// [R16] log read: 8 bytes, indexed, 31:24 zero
// [R17] pin select: overtemp, overcurrent, channels
// [R18] pin select written only with conversion off; taken here also while only the other rail converts
// [R19] sync writes need conversion off, apply at boot; taken here also while only the other rail converts
// [R20] bit 47 sync out, divider 0..15
// [R21] loop gains 1,2,4,8 and 1 or 0.5
// [R22] ratio code 100b never used
// [R23] power-of-two dividers up to Ah
// [R24] flags stay until global or one-bit clear
// [R25] angle offset steps up to 1100b
// [R26] loop enables, sync source and output select
// [R27] unsupported sync values refused and flagged
// [R28] reserved bits read zero, ignore writes
`timescale 1ns/1ps
`default_nettype none
`include "pmbus_ext_regs.svh"
module pmbus_ext_flags_sync_cfg (
  input  wire logic        mclk,
  input  wire logic        nrst,
  input  wire logic        cmd_valid,
  input  wire logic        cmd_write,
  input  wire logic        cmd_block,
  input  wire logic [7:0]  cmd_code,
  input  wire logic [3:0]  cmd_len,
  input  wire logic [7:0]  cmd_blk_size,
  input  wire logic [63:0] cmd_wdata,
  input  wire logic [7:0]  page,
  input  wire logic        write_protect,
  input  wire logic        conv_on_a,
  input  wire logic        conv_on_b,
  input  wire logic        global_fault_clear,
  input  wire logic        ev_malformed_group,
  input  wire logic        ev_group_read,
  input  wire logic        ev_comm_misc,
  input  wire logic        ev_aborted,
  input  wire logic        ev_arbitration_loss_flag,
  input  wire logic        ev_blocksize_nack,
  input  wire logic        pos_sense_open_b,
  input  wire logic        pos_sense_open_a,
  input  wire logic        neg_sense_open_b,
  input  wire logic        neg_sense_open_a,
  input  wire logic        clock_align_fault,
  input  wire logic        bad_boot_flag,
  input  wire logic        bad_addr_pin_flag,
  input  wire logic        bad_phase_map_flag,
  input  wire logic        bad_cfg_file_flag,
  input  wire logic        aux_out_low_b,
  input  wire logic        aux_out_low_a,
  input  wire logic        prebias_overvolt_b,
  input  wire logic        prebias_overvolt_a,
  input  wire logic        tracking_overvolt_b,
  input  wire logic        tracking_overvolt_a,
  input  wire logic        fixed_overvolt_b,
  input  wire logic        fixed_overvolt_a,
  input  wire logic        overtemp_a,
  input  wire logic        overtemp_b,
  input  wire logic        overcurrent_a,
  input  wire logic        overcurrent_b,
  input  wire logic [4:0]  log_entry_index,
  input  wire logic [15:0] nvm_fault_pin_select,
  input  wire logic [47:0] nvm_sync_settings,
  input  wire logic        link_clk,
  input  wire logic        link_data,
  output logic             rsp_valid,
  output logic [63:0]      rsp_data,
  output logic [3:0]       rsp_len,
  output logic             regulator_fault_n,
  output logic [55:0]      extended_fault_flags,
  output logic [47:0]      sync_settings,
  output pmbus_ext_pkg::sync_cfg_t sync_applied
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  logic        booted;
  logic [15:0] fault_pin_select;
  logic [63:0] log_word;
  logic        is_flags;
  logic        is_log;
  logic        is_fpin;
  logic        is_sync;
  logic        ours;
  logic [3:0]  need_len;
  logic        wr;
  logic        len_err;
  logic        blk_err;
  logic        wr_ok;
  logic        conv_ok;
  logic        sync_ok;
  logic        upd_err;
  logic        data_err;
  logic        commit_fpin;
  logic        commit_sync;
  logic [55:0] set_vec;
  logic [55:0] clr_vec;
  logic        fault_a;
  logic        fault_b;
  pmbus_ext_pkg::sync_cfg_t wcfg;

  frame_logger u_log (
    .mclk        (mclk),
    .nrst        (nrst),
    .link_clk    (link_clk),
    .link_data   (link_data),
    .entry_index (log_entry_index),
    .entry_data  (log_word),
    .frame_done  ()
  );

  sticky_bits #(.W(56), .MASK(`FLAGS_MASK)) u_flags (
    .mclk    (mclk),
    .nrst    (nrst),
    .set_vec (set_vec),
    .clr_vec (clr_vec),
    .q       (extended_fault_flags)
  );

  // command decode
  assign is_flags = (cmd_code == `CMD_FLAGS);
  assign is_log   = (cmd_code == `CMD_LOG);
  assign is_fpin  = (cmd_code == `CMD_FPIN);
  assign is_sync  = (cmd_code == `CMD_SYNC);
  assign ours     = is_flags | is_log | is_fpin | is_sync;
  assign wr       = booted && cmd_valid && cmd_write && ours;

  always_comb begin
    need_len = `LEN_FLAGS;
    if (is_log) begin
      need_len = `LEN_LOG;
    end else if (is_fpin) begin
      need_len = `LEN_FPIN;
    end else if (is_sync) begin
      need_len = `LEN_SYNC;
    end
  end

  // checks in priority order: access, count, block size, protect
  assign len_err = wr && !is_log && (cmd_len != need_len); // R06
  assign blk_err = wr && !is_log && !len_err && cmd_block &&
                   (cmd_blk_size != {4'h0, need_len}); // R07
  assign wr_ok   = wr && !is_log && !len_err && !blk_err &&
                   !write_protect; // R08

  // a rail may be reconfigured while only the other rail converts
  assign conv_ok = !(conv_on_a || conv_on_b) ||
                   (page == `PAGE_A && !conv_on_a) ||
                   (page == `PAGE_B && !conv_on_b); // R18

  assign wcfg = pmbus_ext_pkg::sync_cfg_t'(cmd_wdata[47:0]);
  assign sync_ok = (wcfg.in_div <= `IN_DIV_MAX) && // R20
                   (wcfg.freq_ratio_a != `RATIO_BAD) && // R22
                   (wcfg.freq_ratio_b != `RATIO_BAD) &&
                   (wcfg.pwm_pow2_divider_a <= `POW2_MAX) && // R23
                   (wcfg.pwm_pow2_divider_b <= `POW2_MAX) &&
                   (wcfg.angle_offset_a <= `ANGLE_MAX) && // R25
                   (wcfg.angle_offset_b <= `ANGLE_MAX);

  assign upd_err     = wr_ok && (is_fpin || is_sync) && !conv_ok; // R10
  assign data_err    = wr_ok && is_sync && conv_ok && !sync_ok; // R27
  assign commit_fpin = wr_ok && is_fpin && conv_ok; // R18
  assign commit_sync = wr_ok && is_sync && conv_ok && sync_ok; // R19

  always_comb begin
    set_vec = `NO_BITS;
    set_vec[`B_RO_WRITE]   = wr && is_log; // R01
    set_vec[`B_BAD_GROUP]  = ev_malformed_group; // R02
    set_vec[`B_GROUP_READ] = ev_group_read;
    set_vec[`B_COMM_MISC]  = ev_comm_misc || data_err; // R03
    set_vec[`B_ABORTED]    = ev_aborted; // R04
    set_vec[`B_ARB_LOSS]   = ev_arbitration_loss_flag;
    set_vec[`B_BLK_NACK]   = ev_blocksize_nack; // R05
    set_vec[`B_BYTES_FEW]  = len_err && (cmd_len < need_len); // R06
    set_vec[`B_BYTES_MANY] = len_err && (cmd_len > need_len);
    set_vec[`B_BLK_SHORT]  = blk_err &&
                             (cmd_blk_size < {4'h0, need_len}); // R07
    set_vec[`B_BLK_LONG]   = blk_err &&
                             (cmd_blk_size > {4'h0, need_len});
    set_vec[`B_LOCKED]     = wr && !is_log && !len_err && !blk_err &&
                             write_protect; // R08
    set_vec[`B_POS_OPEN_B] = pos_sense_open_b; // R09
    set_vec[`B_POS_OPEN_A] = pos_sense_open_a;
    set_vec[`B_NEG_OPEN_B] = neg_sense_open_b;
    set_vec[`B_NEG_OPEN_A] = neg_sense_open_a;
    set_vec[`B_ALIGN_FLT]  = clock_align_fault; // R10
    set_vec[`B_NO_UPDATE]  = upd_err;
    set_vec[`B_BAD_BOOT]   = bad_boot_flag;
    set_vec[`B_BAD_ADDR]   = bad_addr_pin_flag; // R11
    set_vec[`B_BAD_PHASE]  = bad_phase_map_flag;
    set_vec[`B_BAD_FILE]   = bad_cfg_file_flag;
    set_vec[`B_AUX_LOW_B]  = aux_out_low_b; // R12
    set_vec[`B_AUX_LOW_A]  = aux_out_low_a;
    set_vec[`B_PRE_OV_B]   = prebias_overvolt_b; // R13
    set_vec[`B_PRE_OV_A]   = prebias_overvolt_a;
    set_vec[`B_TRK_OV_B]   = tracking_overvolt_b; // R14
    set_vec[`B_TRK_OV_A]   = tracking_overvolt_a;
    set_vec[`B_FIX_OV_B]   = fixed_overvolt_b;
    set_vec[`B_FIX_OV_A]   = fixed_overvolt_a;
  end

  // one-bit clear by writing ones, or everything at once
  always_comb begin
    clr_vec = `NO_BITS;
    if (global_fault_clear) begin
      clr_vec = `ALL_ONES; // R24
    end else if (wr_ok && is_flags) begin
      clr_vec = cmd_wdata[55:0]; // R24
    end
  end

  // stored images are fetched once after reset, as at power-up
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      booted <= 1'b0;
    end else begin
      booted <= 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      fault_pin_select <= 16'h0000;
    end else if (!booted) begin
      fault_pin_select <= nvm_fault_pin_select & `FPIN_MASK; // R28
    end else if (commit_fpin) begin
      fault_pin_select <= cmd_wdata[15:0] & `FPIN_MASK; // R28
    end
  end

  // staged value is what the host reads and the store saves
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      sync_settings <= 48'h0000_0000_0000;
    end else if (!booted) begin
      sync_settings <= nvm_sync_settings & `SYNC_MASK;
    end else if (commit_sync) begin
      sync_settings <= cmd_wdata[47:0] & `SYNC_MASK; // R28
    end
  end

  // loops only ever see the image loaded at power-up
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      sync_applied <= '0;
    end else if (!booted) begin
      sync_applied <= pmbus_ext_pkg::sync_cfg_t'(
                        nvm_sync_settings & `SYNC_MASK); // R19 R21 R26
    end
  end

  // fault pin: channel A always, channel B only when selected
  assign fault_a = (fault_pin_select[`FP_OT] && overtemp_a) ||
                   (fault_pin_select[`FP_OC] && overcurrent_a);
  assign fault_b = (fault_pin_select[`FP_OT] && overtemp_b) ||
                   (fault_pin_select[`FP_OC] && overcurrent_b);

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      regulator_fault_n <= 1'b1;
    end else begin
      regulator_fault_n <= !(fault_a ||
                          (fault_pin_select[`FP_CHB] && fault_b)); // R17
    end
  end

  // read answers one cycle after the request
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rsp_valid <= 1'b0;
      rsp_data  <= 64'h0000_0000_0000_0000;
      rsp_len   <= 4'h0;
    end else begin
      rsp_valid <= booted && cmd_valid && !cmd_write && ours;
      rsp_len   <= need_len;
      if (is_log) begin
        rsp_data <= log_word; // R16
      end else if (is_fpin) begin
        rsp_data <= {48'h0000_0000_0000, fault_pin_select};
      end else if (is_sync) begin
        rsp_data <= {16'h0000, sync_settings};
      end else begin
        rsp_data <= {8'h00, extended_fault_flags};
      end
    end
  end

  sequence s_wr(logic [7:0] code);
    booted && cmd_valid && cmd_write && cmd_code == code;
  endsequence

  sequence s_rd(logic [7:0] code);
    booted && cmd_valid && !cmd_write && cmd_code == code;
  endsequence

  property p_ro_write;
    s_wr(`CMD_LOG) |=> extended_fault_flags[`B_RO_WRITE];
  endproperty
  a_ro_write: assert property (p_ro_write) // R01
    else $error("read-only write not flagged");

  property p_bad_group;
    (ev_malformed_group |=> extended_fault_flags[`B_BAD_GROUP]) and
    (ev_group_read |=> extended_fault_flags[`B_GROUP_READ]);
  endproperty
  a_bad_group: assert property (p_bad_group) // R02
    else $error("group flags not set");

  property p_misc;
    ev_comm_misc |=> extended_fault_flags[`B_COMM_MISC];
  endproperty
  a_misc: assert property (p_misc) // R03
    else $error("misc error not flagged");

  property p_few_bytes;
    s_wr(`CMD_FPIN) and (cmd_len < `LEN_FPIN) |=>
      extended_fault_flags[`B_BYTES_FEW] && $stable(fault_pin_select);
  endproperty
  a_few_bytes: assert property (p_few_bytes) // R06
    else $error("short write not refused");

  property p_locked;
    s_wr(`CMD_SYNC) and (write_protect && cmd_len == `LEN_SYNC &&
      !cmd_block) |=> extended_fault_flags[`B_LOCKED] &&
      $stable(sync_settings);
  endproperty
  a_locked: assert property (p_locked) // R08
    else $error("protected write not refused");

  property p_fpin_gate;
    s_wr(`CMD_FPIN) and (cmd_len == `LEN_FPIN && !cmd_block &&
      !write_protect && conv_on_a && (page != `PAGE_B || conv_on_b)) |=>
      $stable(fault_pin_select) && extended_fault_flags[`B_NO_UPDATE];
  endproperty
  a_fpin_gate: assert property (p_fpin_gate) // R18
    else $error("pin select changed while converting");

  property p_sync_bad;
    s_wr(`CMD_SYNC) and (!sync_ok && !len_err && !blk_err &&
      !write_protect && conv_ok) |=> $stable(sync_settings) &&
      extended_fault_flags[`B_COMM_MISC];
  endproperty
  a_sync_bad: assert property (p_sync_bad) // R27
    else $error("bad sync data accepted");

  property p_applied_fixed;
    booted |=> $stable(sync_applied);
  endproperty
  a_applied_fixed: assert property (p_applied_fixed) // R19
    else $error("applied sync changed after boot");

  property p_log_read;
    s_rd(`CMD_LOG) |=> rsp_valid && rsp_data[31:24] == 8'h00 &&
      rsp_len == `LEN_LOG;
  endproperty
  a_log_read: assert property (p_log_read) // R16
    else $error("log read answer wrong");

  property p_sticky;
    !global_fault_clear && !(wr_ok && is_flags) |=>
      (extended_fault_flags & $past(extended_fault_flags)) ==
      $past(extended_fault_flags);
  endproperty
  a_sticky: assert property (p_sticky) // R24
    else $error("flag dropped without clear");

  property p_reserved;
    (extended_fault_flags & ~`FLAGS_MASK) == `NO_BITS &&
    sync_settings[13] == 1'b0 && fault_pin_select[15:3] == 13'h0000;
  endproperty
  a_reserved: assert property (p_reserved) // R28
    else $error("reserved bit set");
endmodule // pmbus_ext_flags_sync_cfg
`default_nettype wire

//--- verif/frame_source.sv
// serial frame source standing on the far side of the log input
`timescale 1ns/1ps
`default_nettype none
module frame_source (
  output logic link_clk,
  output logic link_data
);
  initial begin
    link_clk  = 1'b0;
    link_data = 1'b1;
  end
  // clock stands still between frames; released data shows the inverse
  task automatic send(input logic [31:0] frame);
    #7;
    for (int i = 31; i >= 0; i--) begin
      link_data = frame[i];
      #100 link_clk = 1'b1;
      #100 link_clk = 1'b0;
    end
    link_data = ~frame[0];
  endtask
endmodule // frame_source
`default_nettype wire

//--- verif/pmbus_ext_flags_sync_cfg_test.sv
// self-checking bench for the extended flag and sync settings bank
`timescale 1ns/1ps
`default_nettype none
module pmbus_ext_flags_sync_cfg_test;
  logic        mclk, nrst, cmd_valid, cmd_write, cmd_block;
  logic [7:0]  cmd_code, cmd_blk_size, page;
  logic [3:0]  cmd_len, rsp_len;
  logic [63:0] cmd_wdata, rsp_data;
  logic        write_protect, conv_on_a, conv_on_b, global_fault_clear;
  logic        overtemp_a, overtemp_b, overcurrent_a, overcurrent_b;
  logic [4:0]  log_entry_index;
  logic [15:0] nvm_fault_pin_select;
  logic [47:0] nvm_sync_settings, sync_settings;
  logic        link_clk, link_data, rsp_valid, regulator_fault_n;
  logic [55:0] extended_fault_flags;
  logic [22:0] ev;
  pmbus_ext_pkg::sync_cfg_t sync_applied;
  int          n_fail, comparisons;
  localparam logic [47:0] NVS = 48'h8a09_3232_5fe0;
  int unsigned bitpos [23] = '{54, 53, 52, 51, 50, 49, 39, 38, 37, 36,
    28, 25, 24, 19, 18, 15, 14, 5, 4, 3, 2, 1, 0};
  logic [47:0] bad_sync [4] = '{48'h2000_0000_0000, 48'h0020_0000_0000,
    48'h0000_0b00_0000, 48'h0000_00d0_0000};

  pmbus_ext_flags_sync_cfg uut (
    .mclk, .nrst, .cmd_valid, .cmd_write, .cmd_block, .cmd_code,
    .cmd_len, .cmd_blk_size, .cmd_wdata, .page, .write_protect,
    .conv_on_a, .conv_on_b, .global_fault_clear,
    .ev_malformed_group(ev[0]), .ev_group_read(ev[1]),
    .ev_comm_misc(ev[2]), .ev_aborted(ev[3]), .ev_arbitration_loss_flag(ev[4]),
    .ev_blocksize_nack(ev[5]), .pos_sense_open_b(ev[6]),
    .pos_sense_open_a(ev[7]), .neg_sense_open_b(ev[8]),
    .neg_sense_open_a(ev[9]), .clock_align_fault(ev[10]),
    .bad_boot_flag(ev[11]), .bad_addr_pin_flag(ev[12]),
    .bad_phase_map_flag(ev[13]), .bad_cfg_file_flag(ev[14]),
    .aux_out_low_b(ev[15]), .aux_out_low_a(ev[16]),
    .prebias_overvolt_b(ev[17]), .prebias_overvolt_a(ev[18]),
    .tracking_overvolt_b(ev[19]), .tracking_overvolt_a(ev[20]),
    .fixed_overvolt_b(ev[21]), .fixed_overvolt_a(ev[22]),
    .overtemp_a, .overtemp_b, .overcurrent_a, .overcurrent_b,
    .log_entry_index, .nvm_fault_pin_select, .nvm_sync_settings,
    .link_clk, .link_data, .rsp_valid, .rsp_data, .rsp_len,
    .regulator_fault_n, .extended_fault_flags, .sync_settings,
    .sync_applied
  );
  frame_source far (.link_clk, .link_data);

  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  task automatic chk(string nm, logic [63:0] exp, logic [63:0] got);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic tick(int n);
    repeat (n) @(negedge mclk);
  endtask
  // gap first so back-to-back calls never retoggle the strobe at once
  task automatic cmd(logic w, logic [7:0] c, logic [3:0] n,
                     logic [63:0] d);
    tick(1);
    cmd_valid = 1'b1;
    cmd_write = w;
    cmd_code  = c;
    cmd_len   = n;
    cmd_wdata = d;
    tick(1);
    cmd_valid = 1'b0;
  endtask
  task automatic clr;
    global_fault_clear = 1'b1;
    tick(1);
    global_fault_clear = 1'b0;
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    #1_000_000;
    n_fail++;
    wrap_up();
  end

  initial begin
    {cmd_valid, cmd_write, cmd_block, write_protect, conv_on_a} = '0;
    {conv_on_b, global_fault_clear, overtemp_a, overtemp_b} = '0;
    {overcurrent_a, overcurrent_b, cmd_code, cmd_len, page, ev} = '0;
    {cmd_blk_size, cmd_wdata, log_entry_index} = '0;
    nvm_fault_pin_select = 16'h0002;
    nvm_sync_settings = NVS;
    n_fail = 0;
    comparisons = 0;
    nrst = 1'b0;
    tick(4);
    chk("flags in reset", 64'h0, extended_fault_flags);
    chk("pin in reset", 64'h1, regulator_fault_n);
    nrst = 1'b1;
    tick(2);
    chk("applied sync", NVS, sync_applied);
    chk("staged sync", NVS, sync_settings);
    $display("done: reset");
    foreach (bitpos[i]) begin
      ev[i] = 1'b1;
      tick(1);
      ev[i] = 1'b0;
      chk("flag set", 64'h1 << bitpos[i], extended_fault_flags);
      if (i % 2)
        clr();
      else
        cmd(1'b1, 8'hdd, 4'h7, 64'h1 << bitpos[i]);
      chk("flag cleared", 64'h0, extended_fault_flags);
    end
    ev[0] = 1'b1;
    clr();
    ev[0] = 1'b0;
    cmd(1'b0, 8'hdd, 4'h0, 64'h0);
    chk("flags strobe", 64'h1, rsp_valid);
    chk("set beats clear", 64'h1 << 54, rsp_data);
    chk("flags length", 64'h7, rsp_len);
    clr();
    $display("done: flag table");
    cmd(1'b1, 8'he0, 4'h8, 64'h0);
    cmd(1'b1, 8'he3, 4'h1, 64'h7);
    cmd(1'b1, 8'he3, 4'h3, 64'h7);
    cmd_block = 1'b1;
    cmd_blk_size = 8'h06;
    cmd(1'b1, 8'hdd, 4'h7, 64'h0);
    cmd_blk_size = 8'h08;
    cmd(1'b1, 8'hdd, 4'h7, 64'h0);
    cmd_block = 1'b0;
    write_protect = 1'b1;
    cmd(1'b1, 8'he3, 4'h2, 64'h7);
    cmd(1'b1, 8'he4, 4'h6, 64'h0);
    write_protect = 1'b0;
    chk("refusals", 64'h0080_3e00_0000_0000, extended_fault_flags);
    cmd(1'b0, 8'he3, 4'h0, 64'h0);
    chk("pin select kept", 64'h2, rsp_data);
    clr();
    conv_on_a = 1'b1;
    cmd(1'b1, 8'he3, 4'h2, 64'h7);
    cmd(1'b1, 8'he4, 4'h6, 64'h0);
    chk("no update", 64'h1 << 26, extended_fault_flags);
    chk("sync gated", NVS, sync_settings);
    page = 8'h01;
    cmd(1'b1, 8'he3, 4'h2, 64'hfff7);
    cmd(1'b0, 8'he3, 4'h0, 64'h0);
    chk("pin select", 64'h7, rsp_data);
    chk("pin length", 64'h2, rsp_len);
    clr();
    $display("done: refusals");
    overtemp_b = 1'b1;
    tick(2);
    chk("pin on b", 64'h0, regulator_fault_n);
    cmd(1'b1, 8'he3, 4'h2, 64'h6);
    tick(2);
    chk("pin a only", 64'h1, regulator_fault_n);
    overtemp_b = 1'b0;
    overcurrent_a = 1'b1;
    tick(2);
    chk("pin on current", 64'h0, regulator_fault_n);
    overcurrent_a = 1'b0;
    {conv_on_a, page} = '0;
    $display("done: fault pin");
    foreach (bad_sync[i]) begin
      cmd(1'b1, 8'he4, 4'h6, {16'h0, bad_sync[i]});
      chk("bad sync", 64'h1 << 52, extended_fault_flags);
      chk("sync kept", NVS, sync_settings);
      clr();
    end
    cmd(1'b1, 8'he4, 4'h6, 64'h0e3f_aa55_ffff);
    cmd(1'b0, 8'he4, 4'h0, 64'h0);
    chk("sync read", 64'h0e3f_aa55_dfe0, rsp_data);
    chk("sync length", 64'h6, rsp_len);
    chk("not applied", NVS, sync_applied);
    $display("done: sync");
    far.send(32'h1234_5678);
    tick(8);
    cmd(1'b0, 8'he0, 4'h0, 64'h0);
    chk("log entry", 64'h12_3456_7800, rsp_data[63:24]);
    chk("log length", 64'h8, rsp_len);
    $display("done: log");
    nrst = 1'b0;
    tick(1);
    chk("staged in reset", 64'h0, sync_settings);
    chk("strobe in reset", 64'h0, rsp_valid);
    nrst = 1'b1;
    tick(2);
    chk("staged reload", NVS, sync_settings);
    chk("applied reload", NVS, sync_applied);
    $display("done: reset again");
    wrap_up();
  end
endmodule // pmbus_ext_flags_sync_cfg_test
`default_nettype wire
